// *** hdl/ata_cmd_map.vh ***
/*
 * Constants for the drive command block: task-file register indices,
 * command opcodes, status and error bit positions, power states and the
 * standby timer figures.
 * Assumes inclusion by bare name from the design files under hdl/.
 */
`ifndef ATA_CMD_MAP_VH
`define ATA_CMD_MAP_VH

// ====================================================================
// Register indices on the plain register port.
`define REG_DATA        4'h0
`define REG_FAULT_CAUSE 4'h1
`define REG_SECT_COUNT  4'h2
`define REG_DEVICE      4'h6
`define REG_CMD_STATUS  4'h7
`define REG_CONTROL     4'h8
`define REG_POWER       4'h9
`define REG_GEOMETRY    4'hA
`define REG_FEATURE     4'hB

// ====================================================================
// Command opcodes.
`define OP_IDLE_A      8'hE3
`define OP_IDLE_B      8'h97
`define OP_IDLE_IMM_A  8'hE1
`define OP_IDLE_IMM_B  8'h95
`define OP_GEOMETRY    8'h91
`define OP_READ_BUF    8'hE4
`define OP_WRITE_BUF   8'hE8
`define FEAT_KEEP_GEOM 8'hCC

// ====================================================================
// Status and error bit positions.
`define ST_BSY 7
`define ST_RDY 6
`define ST_DSC 4
`define ST_DRQ 3
`define ST_ERR 0
`define ER_ABT 2
`define CTL_SRST 2

// ====================================================================
// Power states.
`define PWR_STANDBY 2'h0
`define PWR_IDLE    2'h1

// ====================================================================
// Standby timer: default and unit in seconds, clock rate in hertz, one tick per second.
`define STBY_DEFAULT_S 32'd6540
`define STBY_UNIT_S    32'd5
`define CLOCK_HZ       32'd40000000

`endif

// *** hdl/ata_idle_param_buffer_cmds.v ***
/*
 * Command-execution logic for the drive's idle, idle immediate, geometry
 * and buffer readback commands, with task-file registers on a plain
 * register port (read data one cycle after the read strobe).
 * Assumes the host adapter is on the same clock and that the spindle
 * driver answers a spin-up request with a level that comes from another
 * domain and is synchronised here.
 */
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "ata_cmd_map.vh"

module ata_idle_param_buffer_cmds #(
   parameter SECTOR_WORDS = 256,
   parameter BUF_WORDS = 1024,
   parameter [31:0] TICKS_PER_SEC = `CLOCK_HZ,
   parameter [31:0] STBY_DEFAULT_S = `STBY_DEFAULT_S
) (
   // Clock, reset and clock enable.
   input wire clock,
   input wire rstn,
   input wire clkEn,
   // Register port.
   input wire [3:0] regAddr,
   input wire [15:0] regWrData,
   input wire regWr,
   input wire regRd,
   output reg [15:0] regRdData,
   // Spindle control.
   output wire spinUpReq,
   input wire spinningIn,
   // Media side access to the sector buffer.
   input wire mediaWr,
   input wire [9:0] mediaAddr,
   input wire [15:0] mediaData,
   // Identify data port for words 54 to 58.
   input wire [7:0] identWord,
   output reg [15:0] identData
);

   // Buffer address width, fixed at 10 bits whatever its depth.
   localparam AW = 10;

   reg [15:0] buffer [0:BUF_WORDS-1];
   reg spinMeta_r;
   reg spinSync_r;
   reg [1:0] power_r;
   reg spinReq_r;
   reg busy_r;
   reg drq_r;
   reg err_r;
   reg abort_r;
   reg [7:0] sectCnt_r;
   reg [7:0] device_r;
   reg [7:0] feature_r;
   reg [7:0] control_r;
   reg [7:0] geomSectors_r;
   reg [3:0] geomHeads_r;
   reg keepGeom_r;
   reg [31:0] interval_r;
   reg [31:0] secLeft_r;
   reg [31:0] tick_r;
   reg [AW-1:0] regionBase_r;
   reg [AW-1:0] wordPtr_r;
   reg [8:0] wordsLeft_r;
   reg [15:0] rdWord;

   wire cmdWr = regWr && (regAddr == `REG_CMD_STATUS);
   wire [7:0] opcode = regWrData[7:0];
   wire hostAccess = regWr || regRd;
   wire dataRd = regRd && (regAddr == `REG_DATA) && drq_r;
   wire srstRise = regWr && (regAddr == `REG_CONTROL) &&
      regWrData[`CTL_SRST] && !control_r[`CTL_SRST];

   // Timeout parameter to seconds; zero means the long default.
   function [31:0] toSeconds;
      input [7:0] p;
      begin
         if (p == 8'h00) begin
            toSeconds = STBY_DEFAULT_S;
         end else begin
            toSeconds = {24'h000000, p} * `STBY_UNIT_S;
         end
      end
   endfunction

   // Spin-up level, held until the spindle reports speed.
   assign spinUpReq = spinReq_r;

   // ==================================================================
   // Spindle status synchroniser; only the second stage is used.
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         spinMeta_r <= 1'b0;
         spinSync_r <= 1'b0;
      end else if (clkEn) begin
         spinMeta_r <= spinningIn;
         spinSync_r <= spinMeta_r;
      end
   end

   // ==================================================================
   // Sector buffer: media writes land here, so a readback may see them.
   always @(posedge clock) begin
      if (clkEn && mediaWr) begin
         buffer[mediaAddr] <= mediaData;
      end
   end

   // ==================================================================
   // Command execution, power state, timer and task-file registers.
   // Commands complete in one cycle except readback, which holds DRQ.
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         power_r <= `PWR_STANDBY;
         spinReq_r <= 1'b0;
         busy_r <= 1'b0;
         drq_r <= 1'b0;
         err_r <= 1'b0;
         abort_r <= 1'b0;
         sectCnt_r <= 8'h00;
         device_r <= 8'h00;
         feature_r <= 8'h00;
         control_r <= 8'h00;
         geomSectors_r <= 8'h00;
         geomHeads_r <= 4'h0;
         keepGeom_r <= 1'b0;
         interval_r <= 32'd0;
         secLeft_r <= 32'd0;
         tick_r <= 32'd0;
         regionBase_r <= {AW{1'b0}};
         wordPtr_r <= {AW{1'b0}};
         wordsLeft_r <= 9'd0;
      end else if (clkEn) begin
         // Spin-up request drops once the spindle is at speed.
         if (spinReq_r && spinSync_r) begin
            spinReq_r <= 1'b0;
         end
         // One-second tick and countdown while idle with a timer set.
         if (power_r == `PWR_IDLE && interval_r != 32'd0) begin
            if (hostAccess) begin
               secLeft_r <= interval_r;
               tick_r <= 32'd0;
            end else if (tick_r >= TICKS_PER_SEC - 32'd1) begin
               tick_r <= 32'd0;
               if (secLeft_r <= 32'd1) begin
                  power_r <= `PWR_STANDBY;
                  secLeft_r <= 32'd0;
               end else begin
                  secLeft_r <= secLeft_r - 32'd1;
               end
            end else begin
               tick_r <= tick_r + 32'd1;
            end
         end
         // Task-file writes.
         if (regWr) begin
            case (regAddr)
               `REG_SECT_COUNT: sectCnt_r <= regWrData[7:0];
               `REG_DEVICE: device_r <= regWrData[7:0];
               `REG_FEATURE: begin
                  feature_r <= regWrData[7:0];
                  if (regWrData[7:0] == `FEAT_KEEP_GEOM) begin
                     keepGeom_r <= 1'b1;
                  end
               end
               `REG_CONTROL: control_r <= regWrData[7:0];
               default: ;
            endcase
         end
         // Soft reset clears command state and, with CCh set, geometry.
         if (srstRise) begin
            drq_r <= 1'b0;
            busy_r <= 1'b0;
            err_r <= 1'b0;
            abort_r <= 1'b0;
            if (keepGeom_r) begin
               geomSectors_r <= 8'h00;
               geomHeads_r <= 4'h0;
            end
         end else if (cmdWr) begin
            err_r <= 1'b0;
            abort_r <= 1'b0;
            busy_r <= 1'b0;
            drq_r <= 1'b0;
            case (opcode)
               `OP_IDLE_A, `OP_IDLE_B: begin
                  if (power_r == `PWR_STANDBY) begin
                     power_r <= `PWR_IDLE;
                  end
                  // An idle state is kept as it is.
                  interval_r <= toSeconds(sectCnt_r);
                  secLeft_r <= toSeconds(sectCnt_r);
                  tick_r <= 32'd0;
                  if (!spinSync_r) begin
                     spinReq_r <= 1'b1;
                  end
               end
               `OP_IDLE_IMM_A, `OP_IDLE_IMM_B: begin
                  power_r <= `PWR_IDLE;
                  secLeft_r <= interval_r;
                  if (!spinSync_r) begin
                     spinReq_r <= 1'b1;
                  end
               end
               `OP_GEOMETRY: begin
                  geomSectors_r <= sectCnt_r;
                  geomHeads_r <= device_r[3:0];
               end
               `OP_WRITE_BUF: begin
                  regionBase_r <= {AW{1'b0}};
               end
               `OP_READ_BUF: begin
                  wordPtr_r <= regionBase_r;
                  wordsLeft_r <= SECTOR_WORDS[8:0] - 9'd1;
                  drq_r <= 1'b1;
               end
               default: begin
                  err_r <= 1'b1;
                  abort_r <= 1'b1;
               end
            endcase
         end else if (dataRd) begin
            // One word per data read until the sector is gone.
            wordPtr_r <= wordPtr_r + {{(AW-1){1'b0}}, 1'b1};
            if (wordsLeft_r == 9'd0) begin
               drq_r <= 1'b0;
            end else begin
               wordsLeft_r <= wordsLeft_r - 9'd1;
            end
         end
         // Keep the spindle turning in idle.
         if (power_r == `PWR_IDLE && !spinSync_r && !spinReq_r) begin
            spinReq_r <= 1'b1;
         end
      end
   end

   // ==================================================================
   // Read multiplexer for the register port.
   always @* begin
      case (regAddr)
         `REG_DATA: begin
            rdWord = drq_r ? buffer[wordPtr_r] : 16'h0000;
         end
         `REG_FAULT_CAUSE: rdWord = {13'h0000, abort_r, 2'h0};
         `REG_SECT_COUNT: rdWord = {8'h00, sectCnt_r};
         `REG_DEVICE: rdWord = {8'h00, device_r};
         `REG_CMD_STATUS: rdWord = {8'h00, busy_r, !busy_r, 1'b0,
            spinSync_r, drq_r, 2'h0, err_r};
         `REG_CONTROL: rdWord = {8'h00, control_r};
         `REG_POWER: rdWord = {14'h0000, power_r};
         `REG_GEOMETRY: rdWord = {4'h0, geomHeads_r, geomSectors_r};
         `REG_FEATURE: rdWord = {8'h00, feature_r};
         default: rdWord = 16'h0000;
      endcase
   end

   // Read data stand one cycle after the strobe.
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         regRdData <= 16'h0000;
      end else if (clkEn) begin
         regRdData <= regRd ? rdWord : 16'h0000;
      end
   end

   // ==================================================================
   // Identify words 54 to 58; words 55 and 56 built from stored geometry.
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         identData <= 16'h0000;
      end else if (clkEn) begin
         case (identWord)
            8'd54: identData <= 16'h3FFF;
            8'd55: identData <= {11'h000, 1'b0, geomHeads_r} +
               16'h0001;
            8'd56: identData <= {8'h00, geomSectors_r};
            8'd57: identData <= 16'h0000;
            8'd58: identData <= 16'h0000;
            default: identData <= 16'h0000;
         endcase
      end
   end

endmodule // ata_idle_param_buffer_cmds
`default_nettype wire

// *** test/ata_idle_param_buffer_cmds_chk.sv ***
/* Port checker for the drive command block: register read timing,
   status and error bits, identify word 54 and the spin-up request.
   Assumes it is bound to the block's top and sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
// ==============================================================
// Checker module.
module ata_idle_param_buffer_cmds_chk (
   // Clock and reset.
   input wire logic clock,
   input wire logic rstn,
   // Register port.
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [15:0] regRdData,
   // Spindle and identify.
   input wire logic spinUpReq,
   input wire logic spinningIn,
   input wire logic [7:0] identWord,
   input wire logic [15:0] identData
);
   logic [2:0] sameCnt_r;
   logic lastSpin_r;
   wire [7:0] op = regWrData[7:0];
   wire idleOp = regWr && regAddr == 4'h7 &&
      (op == 8'hE3 || op == 8'h97 || op == 8'hE1 || op == 8'h95);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rstn);
   // Cycles the spindle level has held; it saturates so it never wraps.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sameCnt_r <= 3'h0;
         lastSpin_r <= 1'b0;
      end else begin
         lastSpin_r <= spinningIn;
         if (spinningIn != lastSpin_r) begin
            sameCnt_r <= 3'h0;
         end else if (sameCnt_r != 3'h7) begin
            sameCnt_r <= sameCnt_r + 3'h1;
         end
      end
   end
   // Relations between host accesses and the block's answers.
   rd_idle_zero_a: assert property (
      !$past(regRd) |-> regRdData == 16'h0000) else $error("stray data");
   status_bits_a: assert property (
      $past(regRd && regAddr == 4'h7) |-> (regRdData & 16'hFFA4) == 16'h0)
      else $error("busy or fixed status bit set");
   error_bits_a: assert property (
      $past(regRd && regAddr == 4'h1) |-> (regRdData & 16'hFFFB) == 16'h0)
      else $error("error bit other than abort");
   refuse_flag_a: assert property (
      regWr && regAddr == 4'h7 && op == 8'h00 ##[1:2]
      regRd && regAddr == 4'h7 |=> regRdData[0] && regRdData[6])
      else $error("refused command not flagged");
   idle_entry_a: assert property (
      idleOp ##[1:2] regRd && regAddr == 4'h9 |=> regRdData == 16'h0001)
      else $error("idle state not entered");
   ident_cyl_a: assert property (
      $past(identWord) == 8'h36 && $past(rstn) |-> identData == 16'h3FFF)
      else $error("identify word wrong");
   spin_flag_a: assert property (
      $past(regRd && regAddr == 4'h7 && sameCnt_r == 3'h7)
      |-> regRdData[4] == $past(spinningIn)) else $error("spin flag wrong");
   spin_req_a: assert property (
      idleOp && sameCnt_r == 3'h7 && !spinningIn |-> ##[1:4] spinUpReq)
      else $error("no spin-up request");
endmodule // ata_idle_param_buffer_cmds_chk

bind ata_idle_param_buffer_cmds ata_idle_param_buffer_cmds_chk chk (
   .clock, .rstn, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
   .spinUpReq, .spinningIn, .identWord, .identData
);
`default_nettype wire

// *** test/spindle_model.sv ***
/* Spindle driver model: follows the spin-up request after a delay.
   Assumes the request is a level on the bench clock. */
`timescale 1ns/10ps
`default_nettype none
// ==============================================================
// Spindle model.
module spindle_model #(
   parameter int UP = 6,
   parameter int DOWN = 50
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rstn,
   // Request and speed flag.
   input wire logic spinUpReq,
   output var logic spinningIn
);
   int cnt;
   // Spin-down is slow so a late request still finds it turning.
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt <= 0;
         spinningIn <= 1'b0;
      end else if (spinUpReq != spinningIn) begin
         cnt <= cnt + 1;
         if (cnt >= (spinUpReq ? UP : DOWN)) begin
            spinningIn <= spinUpReq;
            cnt <= 0;
         end
      end else begin
         cnt <= 0;
      end
   end
endmodule // spindle_model
`default_nettype wire

// *** test/test_ata_idle_param_buffer_cmds.sv ***
/* Self-checking bench for the drive command block: host register
   accesses, media buffer fill and identify reads.
   Assumes the spindle model answers the spin-up request. */
`timescale 1ns/10ps
`default_nettype none
// ==============================================================
// Bench top.
module test_ata_idle_param_buffer_cmds;
   logic clock, rstn, clkEn, regWr, regRd, mediaWr;
   logic [3:0] regAddr;
   logic [15:0] regWrData, mediaData;
   logic [9:0] mediaAddr;
   logic [7:0] identWord;
   wire [15:0] regRdData, identData;
   wire spinUpReq, spinningIn;
   int errCount = 0;
   int cmpCount = 0;
   int cycles = 0;
   logic [7:0] ops [4] = '{8'hE3, 8'h97, 8'hE1, 8'h95};
   // A timer second of four cycles keeps the countdowns short.
   ata_idle_param_buffer_cmds #(.TICKS_PER_SEC(32'h4)) dut (
      .clock(clock), .rstn(rstn), .clkEn(clkEn), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .spinUpReq(spinUpReq),
      .spinningIn(spinningIn), .mediaWr(mediaWr), .mediaAddr(mediaAddr),
      .mediaData(mediaData), .identWord(identWord), .identData(identData)
   );
   spindle_model spin (.clock(clock), .rstn(rstn), .spinUpReq(spinUpReq),
      .spinningIn(spinningIn));
   // Clock and hang guard.
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         errCount++;
         reportAndStop();
      end
   end
   task automatic reportAndStop;
      $display("mismatches %0d compares %0d", errCount, cmpCount);
      if (errCount == 0 && cmpCount > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         errCount++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Bus cycles: strobes last one cycle, read data follow one cycle on.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e,
      input logic [15:0] m = 16'hFFFF);
      @(posedge clock);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clock);
      regRd <= 1'b0;
      @(negedge clock);
      chk(regRdData & m, e);
   endtask
   task automatic idnt(input logic [7:0] w, input logic [15:0] e);
      @(posedge clock);
      identWord <= w;
      @(posedge clock);
      @(negedge clock);
      chk(identData, e);
   endtask
   // Main sequence; the spindle flag is masked where its timing varies.
   initial begin
      {rstn, regWr, regRd, mediaWr, regAddr, regWrData} = '0;
      {mediaAddr, mediaData, identWord} = '0;
      clkEn = 1'b1;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      rd(4'h7, 16'h0040);
      rd(4'h9, 16'h0000);
      foreach (ops[i]) begin
         wr(4'h2, i < 2 ? 16'h1 : 16'h0);
         wr(4'h7, {8'h00, ops[i]});
         rd(4'h9, 16'h0001);
         repeat (10) @(posedge clock);
         rd(4'h9, 16'h0001);
         repeat (10) @(posedge clock);
         rd(4'h9, 16'h0001);
         repeat (40) @(posedge clock);
         rd(4'h9, 16'h0000);
      end
      wr(4'h2, 16'h0);
      wr(4'h7, 16'h00E3);
      repeat (80) @(posedge clock);
      rd(4'h9, 16'h0001);
      wr(4'h7, 16'h00E1);
      rd(4'h9, 16'h0001);
      wr(4'h7, 16'h0000);
      rd(4'h7, 16'h0041, 16'hFFEF);
      rd(4'h1, 16'h0004);
      wr(4'h6, 16'h00AF);
      wr(4'h7, 16'h0091);
      rd(4'hA, 16'h0F00);
      wr(4'h8, 16'h4);
      wr(4'h8, 16'h0);
      rd(4'hA, 16'h0F00);
      idnt(8'h37, 16'h0010);
      idnt(8'h36, 16'h3FFF);
      wr(4'hB, 16'h00CC);
      wr(4'h8, 16'h4);
      wr(4'h8, 16'h0);
      rd(4'hA, 16'h0000);
      wr(4'h2, 16'h3F);
      wr(4'h6, 16'h00A3);
      wr(4'h7, 16'h0091);
      idnt(8'h38, 16'h003F);
      @(posedge clock);
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      rd(4'hA, 16'h0000);
      // Fill two sectors so a wrong region base shows up.
      for (int i = 0; i < 512; i++) begin
         @(posedge clock);
         mediaWr <= 1'b1;
         mediaAddr <= 10'(i);
         mediaData <= 16'(i) ^ 16'hA500;
      end
      @(posedge clock);
      mediaWr <= 1'b0;
      wr(4'h7, 16'h00E8);
      @(posedge clock);
      mediaWr <= 1'b1;
      mediaAddr <= 10'h5;
      mediaData <= 16'h1234;
      @(posedge clock);
      mediaWr <= 1'b0;
      wr(4'h7, 16'h00E4);
      rd(4'h7, 16'h0048, 16'hFFEF);
      for (int i = 0; i < 256; i++) begin
         rd(4'h0, i == 5 ? 16'h1234 : 16'(i) ^ 16'hA500);
      end
      rd(4'h7, 16'h0040, 16'hFFEF);
      rd(4'h0, 16'h0000);
      reportAndStop();
   end
endmodule // test_ata_idle_param_buffer_cmds
`default_nettype wire
